// ---- core/csd_defines.svh ----
// Purpose: constants of the chip select address decoder
// Assumes: register index times four is the avalon byte address
// Notes: address ranges are inclusive, bank is address bits 23:16
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
`define CSD_IDX_PORT7_CHIP_SELECT_ENABLE      16'hdf27
`define CSD_IDX_BCR       16'hdf40
`define CSD_IDX_SYSTEM_SPEED_CONTROL      16'hdf41
`define CSD_IDX_CFG       16'h0001
`define CSD_IDX_STAT      16'h0002
`define CSD_BCR_RST_STRAP 8'h89
`define CSD_BCR_RST       8'h00
`define CSD_REG_RST       8'h00
`define CSD_SYSTEM_SPEED_CONTROL_RAMSEL   2
`define CSD_CFG_ROMON     0
`define CSD_BANK_ZERO     8'h00
`define CSD_BANK_TOP      8'hff
`define CSD_BANK_LOW_END  8'h3f
`define CSD_BANK_MID_LO   8'h40
`define CSD_BANK_MID_HI   8'hbf
`define CSD_BANK_HIGH_LO  8'hc0
`define CSD_PORTX_LO      16'hdf00
`define CSD_PORTX_HI      16'hdf1f
`define CSD_COPX_LO       16'hdfc0
`define CSD_COPX_HI       16'hdfff
`define CSD_IOBLK_LO      16'hdf00
`define CSD_IOBLK_HI      16'hdfff
`define CSD_IRAM_LO       16'h0000
`define CSD_IRAM_HI       16'h01ff
`define CSD_CACHE_LO      16'h0200
`define CSD_CACHE_HI      16'h7fff
`define CSD_ROMA_LO       16'h8000
`define CSD_ROMA_HI       16'hdeff
`define CSD_ROMB_LO       16'he000
`define CSD_ROMB_HI       16'hffff
`define CSD_VEC_LO        16'hffc0
`define CSD_VEC_HI        16'hffff
`define CSD_SEL_PORTX     0
`define CSD_SEL_COPX      1
`define CSD_SEL_ONCHIP    2
`define CSD_SEL_CACHE     3
`define CSD_SEL_ROM       4
`define CSD_SEL_LOW       5
`define CSD_SEL_MID       6
`define CSD_SEL_HIGH      7
`endif

// ---- core/csd_pkg.sv ----
// Purpose: types of the chip select address decoder
// Assumes: nothing
// Notes: width codes are shared by accumulator and index outputs
package csd_pkg;
  typedef enum logic [1:0] {
    CSD_W8  = 2'h0,
    CSD_W16 = 2'h1,
    CSD_W32 = 2'h2
  } csd_width_e;
  typedef enum logic [1:0] {
    CSD_ST_IDLE = 2'h1,
    CSD_ST_ACK  = 2'h2
  } csd_bus_state_e;
endpackage

// ---- core/csd_top.sv ----
// Purpose: chip select decoder with avalon register slave
// Assumes: cpu address and flags synchronous to clk
// Notes: all outputs registered, one cycle after the address
`timescale 1ns/100ps
`include "csd_defines.svh"
module csd_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        bus_enable_rdy,
  input  wire logic [23:0] cpu_address,
  input  wire logic        cpu_address_valid,
  input  wire logic        emul16_flag,
  input  wire logic        emul8_flag,
  input  wire logic        m_flag,
  input  wire logic        x_flag,
  input  wire logic [7:0]  port7_data,
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             port_expansion_select_n,
  output logic             coproc_expansion_select_n,
  output logic             onchip_select_n,
  output logic             cache_ram_select_n,
  output logic             rom_select_n,
  output logic             low_memory_select_n,
  output logic             mid_user_select_n,
  output logic             high_user_select_n,
  output logic [7:0]       port7_pin_out,
  output csd_pkg::csd_width_e acc_width,
  output csd_pkg::csd_width_e index_width
);

  function automatic logic in_rng(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  // register bus state
  csd_pkg::csd_bus_state_e state_reg;
  csd_pkg::csd_bus_state_e state_next;
  logic [7:0]  port7_chip_select_enable_reg;
  logic [7:0]  port7_chip_select_enable_next;
  logic [7:0]  bcr_reg;
  logic [7:0]  bcr_next;
  logic [7:0]  system_speed_control_reg;
  logic [7:0]  system_speed_control_next;
  logic [7:0]  cfg_reg;
  logic [7:0]  cfg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        wait_reg;
  logic        wait_next;
  logic [15:0] idx;
  logic        wr_low;

  // decode state
  logic [7:0]  sel_reg;
  logic [7:0]  sel_next;
  logic [7:0]  pin_reg;
  logic [7:0]  pin_next;
  csd_pkg::csd_width_e accw_reg;
  csd_pkg::csd_width_e accw_next;
  csd_pkg::csd_width_e idxw_reg;
  csd_pkg::csd_width_e idxw_next;

  logic [7:0]  bank;
  logic [15:0] offs;
  logic        b0;
  logic        bff;
  logic        rom_on;
  logic        ramsel;
  logic        h_portx;
  logic        h_copx;
  logic        h_ioblk;
  logic        h_iram;
  logic        h_vec;
  logic        h_onrom;
  logic        h_onchip;
  logic        h_cache;
  logic        h_rom;
  logic        h_low;
  logic        h_mid;
  logic        h_high;
  logic [7:0]  raw_sel;

  assign idx    = avs_address[17:2];
  assign wr_low = avs_write && avs_byteenable[0];
  assign bank   = cpu_address[23:16];
  assign offs   = cpu_address[15:0];
  assign b0     = bank == `CSD_BANK_ZERO;
  assign bff    = bank == `CSD_BANK_TOP;
  assign rom_on = cfg_reg[`CSD_CFG_ROMON];
  assign ramsel = system_speed_control_reg[`CSD_SYSTEM_SPEED_CONTROL_RAMSEL];

  // avalon slave: one wait cycle, then a single cycle answer
  always_comb begin
    state_next = state_reg;
    port7_chip_select_enable_next  = port7_chip_select_enable_reg;
    bcr_next   = bcr_reg;
    system_speed_control_next  = system_speed_control_reg;
    cfg_next   = cfg_reg;
    rdata_next = rdata_reg;
    wait_next  = 1'b1;
    case (state_reg)
      csd_pkg::CSD_ST_IDLE: begin
        if (avs_read || avs_write) begin
          state_next = csd_pkg::CSD_ST_ACK;
          wait_next  = 1'b0;
          case (idx)
            `CSD_IDX_PORT7_CHIP_SELECT_ENABLE: rdata_next = {24'h000000, port7_chip_select_enable_reg};
            `CSD_IDX_BCR:  rdata_next = {24'h000000, bcr_reg};
            `CSD_IDX_SYSTEM_SPEED_CONTROL: rdata_next = {24'h000000, system_speed_control_reg};
            `CSD_IDX_CFG:  rdata_next = {24'h000000, cfg_reg};
            `CSD_IDX_STAT: rdata_next = {28'h0000000, idxw_reg, accw_reg};
            default:       rdata_next = 32'h00000000;
          endcase
        end
      end
      csd_pkg::CSD_ST_ACK: begin
        // write lands on the edge the master sees waitrequest low
        state_next = csd_pkg::CSD_ST_IDLE;
        if (wr_low) begin
          case (idx)
            `CSD_IDX_PORT7_CHIP_SELECT_ENABLE: port7_chip_select_enable_next = avs_writedata[7:0];
            `CSD_IDX_BCR:  bcr_next  = avs_writedata[7:0];
            `CSD_IDX_SYSTEM_SPEED_CONTROL: system_speed_control_next = avs_writedata[7:0];
            `CSD_IDX_CFG:  cfg_next  = avs_writedata[7:0];
            default:       cfg_next  = cfg_reg;
          endcase
        end
      end
      default: state_next = csd_pkg::CSD_ST_IDLE;
    endcase
    if (reset) begin
      state_next = csd_pkg::CSD_ST_IDLE;
      wait_next  = 1'b1;
      rdata_next = 32'h00000000;
      port7_chip_select_enable_next  = `CSD_REG_RST;
      system_speed_control_next  = `CSD_REG_RST;
      cfg_next   = `CSD_REG_RST;
      // strap level taken while reset is held, synchronous reset
      bcr_next   = bus_enable_rdy ? `CSD_BCR_RST : `CSD_BCR_RST_STRAP;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
    port7_chip_select_enable_reg  <= port7_chip_select_enable_next;
    bcr_reg   <= bcr_next;
    system_speed_control_reg  <= system_speed_control_next;
    cfg_reg   <= cfg_next;
    rdata_reg <= rdata_next;
    wait_reg  <= wait_next;
  end

  // address decode, priority keeps the select vector one-hot
  always_comb begin
    h_portx  = b0 && in_rng(offs, `CSD_PORTX_LO, `CSD_PORTX_HI);
    h_copx   = b0 && in_rng(offs, `CSD_COPX_LO, `CSD_COPX_HI);
    h_ioblk  = b0 && in_rng(offs, `CSD_IOBLK_LO, `CSD_IOBLK_HI);
    h_iram   = b0 && !ramsel && in_rng(offs, `CSD_IRAM_LO, `CSD_IRAM_HI);
    h_vec    = bff && in_rng(offs, `CSD_VEC_LO, `CSD_VEC_HI);
    h_onrom  = rom_on && (b0 || bff) && in_rng(offs, `CSD_ROMB_LO, `CSD_ROMB_HI);
    h_onchip = !h_portx && !h_copx && (h_ioblk || h_iram || h_vec || h_onrom);
    h_cache  = b0 && in_rng(offs, ramsel ? `CSD_IRAM_LO : `CSD_CACHE_LO,
                            `CSD_CACHE_HI);
    h_rom    = b0 && (in_rng(offs, `CSD_ROMA_LO, `CSD_ROMA_HI) ||
                      (!rom_on && in_rng(offs, `CSD_ROMB_LO, `CSD_ROMB_HI)));
    h_low    = (bank <= `CSD_BANK_LOW_END) && !h_ioblk && !h_iram && !h_onrom &&
               !(port7_chip_select_enable_reg[`CSD_SEL_CACHE] && h_cache) &&
               !(port7_chip_select_enable_reg[`CSD_SEL_ROM] && h_rom);
    h_mid    = (bank >= `CSD_BANK_MID_LO) && (bank <= `CSD_BANK_MID_HI);
    h_high   = (bank >= `CSD_BANK_HIGH_LO) && !h_vec && !h_onrom;
    raw_sel  = {h_high, h_mid, h_low, h_rom, h_cache, h_onchip, h_copx, h_portx};
    // a select whose pin is in port mode is never asserted
    sel_next = cpu_address_valid ? (raw_sel & port7_chip_select_enable_reg) : 8'h00;
    if (reset) begin
      sel_next = 8'h00;
    end
  end

  // pin mux per port 7 line
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_comb begin
        pin_next[gi] = port7_chip_select_enable_reg[gi] ? !sel_next[gi] : port7_data[gi];
        if (reset) begin
          pin_next[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // register widths from emulation and width flags
  always_comb begin
    if (m_flag || (emul16_flag && emul8_flag)) begin
      accw_next = csd_pkg::CSD_W8;
    end else if (!emul16_flag && emul8_flag) begin
      accw_next = csd_pkg::CSD_W32;
    end else begin
      accw_next = csd_pkg::CSD_W16;
    end
    if (x_flag || (emul16_flag && emul8_flag)) begin
      idxw_next = csd_pkg::CSD_W8;
    end else if (!emul16_flag) begin
      idxw_next = csd_pkg::CSD_W32;
    end else begin
      idxw_next = csd_pkg::CSD_W16;
    end
    if (reset) begin
      accw_next = csd_pkg::CSD_W16;
      idxw_next = csd_pkg::CSD_W16;
    end
  end

  always_ff @(posedge clk) begin
    sel_reg  <= sel_next;
    pin_reg  <= pin_next;
    accw_reg <= accw_next;
    idxw_reg <= idxw_next;
  end

  assign avs_readdata              = rdata_reg;
  assign avs_waitrequest           = wait_reg;
  assign port_expansion_select_n   = !sel_reg[`CSD_SEL_PORTX];
  assign coproc_expansion_select_n = !sel_reg[`CSD_SEL_COPX];
  assign onchip_select_n           = !sel_reg[`CSD_SEL_ONCHIP];
  assign cache_ram_select_n        = !sel_reg[`CSD_SEL_CACHE];
  assign rom_select_n              = !sel_reg[`CSD_SEL_ROM];
  assign low_memory_select_n       = !sel_reg[`CSD_SEL_LOW];
  assign mid_user_select_n         = !sel_reg[`CSD_SEL_MID];
  assign high_user_select_n        = !sel_reg[`CSD_SEL_HIGH];
  assign port7_pin_out             = pin_reg;
  assign acc_width                 = accw_reg;
  assign index_width               = idxw_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_select_one_hot: assert property ($onehot0(sel_reg))
    else $error("more than one chip select active");
  chk_high_bank: assert property (cpu_address_valid && port7_chip_select_enable_reg[7] &&
      cpu_address[23:22] == 2'h3 && cpu_address[23:16] != 8'hff
      |=> !high_user_select_n)
    else $error("high user select missing");
  chk_mid_bank: assert property (cpu_address_valid && port7_chip_select_enable_reg[6] &&
      cpu_address[23:22] inside {2'h1, 2'h2} |=> !mid_user_select_n)
    else $error("mid user select missing");
  chk_low_bank: assert property (cpu_address_valid && port7_chip_select_enable_reg[5] &&
      cpu_address[23:22] == 2'h0 && cpu_address[23:16] != 8'h00
      |=> !low_memory_select_n)
    else $error("low memory select missing");
  chk_rom_window: assert property (cpu_address_valid && port7_chip_select_enable_reg[4] && !rom_on &&
      cpu_address[23:15] == 9'h001 && cpu_address[14:8] != 7'h5f
      |=> !rom_select_n)
    else $error("rom select missing");
  chk_rom_onchip: assert property (rom_on && cpu_address[23:13] == 11'h007
      |=> rom_select_n)
    else $error("rom select active under on-chip rom");
  chk_ioblk_free: assert property (cpu_address[23:8] == 16'h00df
      |=> rom_select_n && low_memory_select_n)
    else $error("io block reached rom or low memory");
  chk_cache_range: assert property (cpu_address_valid && port7_chip_select_enable_reg[3] && ramsel &&
      cpu_address[23:15] == 9'h000 |=> !cache_ram_select_n)
    else $error("cache select missing in external ram mode");
  chk_cache_internal: assert property (cpu_address_valid && port7_chip_select_enable_reg[3] && !ramsel &&
      cpu_address[23:15] == 9'h000 && cpu_address[14:9] != 6'h00
      |=> !cache_ram_select_n)
    else $error("cache select missing in internal ram mode");
  chk_copx_range: assert property (cpu_address_valid && port7_chip_select_enable_reg[1] &&
      cpu_address[23:6] == 18'h0037f |=> !coproc_expansion_select_n)
    else $error("coprocessor select missing");
  chk_portx_range: assert property (cpu_address_valid && port7_chip_select_enable_reg[0] &&
      cpu_address[23:5] == 19'h006f8 |=> !port_expansion_select_n)
    else $error("port expansion select missing");
  chk_onchip_ram: assert property (cpu_address_valid && port7_chip_select_enable_reg[2] && !ramsel &&
      cpu_address[23:9] == 15'h0000 |=> !onchip_select_n)
    else $error("internal ram select missing");
  chk_vector_area: assert property (cpu_address_valid && port7_chip_select_enable_reg[2] &&
      cpu_address[23:6] == 18'h3ffff |=> !onchip_select_n)
    else $error("vector area select missing");
  chk_portx_excl: assert property (cpu_address[23:5] == 19'h006f8
      |=> onchip_select_n && rom_select_n && low_memory_select_n)
    else $error("port expansion overlaps other selects");
  chk_acc_width: assert property (m_flag |=> acc_width == csd_pkg::CSD_W8)
    else $error("accumulator width not 8");
  chk_index_width: assert property (x_flag |=> index_width == csd_pkg::CSD_W8)
    else $error("index width not 8");
  chk_pin_mux: assert property (!port7_chip_select_enable_reg[0] && !reset |=>
      port7_pin_out[0] == $past(port7_data[0]))
    else $error("port pin not in port mode");
  chk_bus_answer: assert property ($rose(avs_read) && wait_reg |=> !avs_waitrequest)
    else $error("slave answer late");

  cov_rom_select: cover property (!rom_select_n);
  cov_cache_select: cover property (!cache_ram_select_n);
  cov_reg_write: cover property (avs_write && !avs_waitrequest);
  cov_width32: cover property (acc_width == csd_pkg::CSD_W32);
  cov_low_select: cover property (!low_memory_select_n);

endmodule

// ---- tb/csd_ext_mem.sv ----
// Purpose: external memories and peripherals behind the eight chip selects
// Assumes: selects are active low, one device per select line
// Notes: reports which device answers, 8 when none is selected
`timescale 1ns/100ps
module csd_ext_mem (
  input  wire logic [7:0] sel_n,
  output logic [3:0]      dev_id,
  output logic            clash
);
  // two devices answering at once would fight on the data bus
  always_comb begin
    dev_id = 4'h8;
    clash  = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!sel_n[i]) begin
        clash  = clash | (dev_id != 4'h8);
        dev_id = i[3:0];
      end
    end
  end
endmodule

// ---- tb/chip_select_address_decoder_bench.sv ----
// Purpose: self-checking bench of the chip select decoder
// Assumes: avalon slave answers with one cycle of waitrequest low
// Notes: port 7 data fixed so that pins fed from it differ from the selects
`timescale 1ns/100ps
`include "csd_defines.svh"
module chip_select_address_decoder_bench;
  typedef struct packed {logic [23:0] a; logic [1:0] rr; logic [3:0] id;} csd_row_s;
  logic        clk = 1'h0, reset = 1'h1, strap = 1'h0, valid = 1'h0;
  logic        e16 = 1'h0, e8 = 1'h0, mf = 1'h0, xf = 1'h0;
  logic [23:0] addr = 24'h0;
  logic [7:0]  p7d = 8'ha5;
  logic [17:0] aa = 18'h0;
  logic        ar = 1'h0, aw = 1'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0]  be = 4'h1, dev_id;
  logic        wr_n, clash;
  logic [1:0]  ea, ei;
  wire  [7:0]  sn;
  logic [7:0]  pin;
  csd_pkg::csd_width_e acc_o, idx_o;
  int          n_fail = 0, checked = 0;
  logic [31:0] dq;
  csd_row_s    rows [24] = '{
    {24'h00df00, 2'h0, 4'h0}, {24'h00df1f, 2'h0, 4'h0}, {24'h00df20, 2'h0, 4'h2},
    {24'h00dfbf, 2'h0, 4'h2}, {24'h00dfc0, 2'h0, 4'h1}, {24'h00dfff, 2'h0, 4'h1},
    {24'h000000, 2'h0, 4'h2}, {24'h0001ff, 2'h0, 4'h2}, {24'h000000, 2'h2, 4'h3},
    {24'h000200, 2'h0, 4'h3}, {24'h007fff, 2'h0, 4'h3}, {24'h008000, 2'h0, 4'h4},
    {24'h00deff, 2'h0, 4'h4}, {24'h00e000, 2'h0, 4'h4}, {24'h00ffff, 2'h0, 4'h4},
    {24'h00e000, 2'h1, 4'h2}, {24'hffffc0, 2'h0, 4'h2}, {24'hffffbf, 2'h0, 4'h7},
    {24'hffe000, 2'h1, 4'h2}, {24'h010000, 2'h0, 4'h5}, {24'h3fffff, 2'h0, 4'h5},
    {24'h400000, 2'h0, 4'h6}, {24'hbfffff, 2'h0, 4'h6}, {24'hc00000, 2'h0, 4'h7}};

  csd_top dut (
    .clk(clk), .reset(reset), .bus_enable_rdy(strap), .cpu_address(addr),
    .cpu_address_valid(valid), .emul16_flag(e16), .emul8_flag(e8), .m_flag(mf),
    .x_flag(xf), .port7_data(p7d), .avs_address(aa), .avs_read(ar), .avs_write(aw),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rd), .avs_waitrequest(wr_n),
    .port_expansion_select_n(sn[0]), .coproc_expansion_select_n(sn[1]),
    .onchip_select_n(sn[2]), .cache_ram_select_n(sn[3]), .rom_select_n(sn[4]),
    .low_memory_select_n(sn[5]), .mid_user_select_n(sn[6]), .high_user_select_n(sn[7]),
    .port7_pin_out(pin), .acc_width(acc_o), .index_width(idx_o)
  );
  csd_ext_mem mem (.sel_n(sn), .dev_id(dev_id), .clash(clash));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d comparisons", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // request held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    @(posedge clk);
    aa <= {i, 2'h0};
    aw <= w;
    ar <= !w;
    wd <= {24'h0, d};
    be <= b;
    // low waitrequest stands up to the edge that completes the access
    @(negedge clk);
    while (wr_n !== 1'b0) begin
      @(negedge clk);
    end
    q = rd;
    @(posedge clk);
    ar <= 1'b0;
    aw <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, 4'h1, q);
  endtask

  task automatic rdchk(input logic [15:0] i, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, i, 8'h0, 4'h1, q);
    chk(q, {24'h0, e});
  endtask

  // pins show the select where enabled, port data elsewhere
  task automatic dec(input logic [23:0] a, input logic v, input logic [3:0] id,
                     input logic [7:0] en);
    logic [7:0] es;
    es = (id == 4'h8) ? 8'hff : ~(8'h1 << id);
    @(posedge clk);
    addr  <= a;
    valid <= v;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({24'h0, sn}, {24'h0, es});
    chk({24'h0, pin}, {24'h0, (es & en) | (p7d & ~en)});
    chk({28'h0, dev_id}, {28'h0, id});
    chk({31'h0, clash}, 32'h0);
  endtask

  task automatic rst(input logic s);
    reset <= 1'b1;
    strap <= s;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({23'h0, wr_n, sn}, 32'h1ff);
    chk({rd[29:0], acc_o}, 32'h1);
    chk({24'h0, pin}, 32'hff);
    @(posedge clk);
    reset <= 1'b0;
  endtask

  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    rst(1'b0);
    rdchk(`CSD_IDX_BCR, 8'h89);
    rdchk(`CSD_IDX_PORT7_CHIP_SELECT_ENABLE, 8'h00);
    rdchk(`CSD_IDX_SYSTEM_SPEED_CONTROL, 8'h00);
    wr(`CSD_IDX_BCR, 8'h3c);
    rdchk(`CSD_IDX_BCR, 8'h3c);
    wr(`CSD_IDX_PORT7_CHIP_SELECT_ENABLE, 8'hff);
    rdchk(`CSD_IDX_PORT7_CHIP_SELECT_ENABLE, 8'hff);
    for (int i = 0; i < 24; i++) begin
      wr(`CSD_IDX_SYSTEM_SPEED_CONTROL, {5'h0, rows[i].rr[1], 2'h0});
      wr(`CSD_IDX_CFG, {7'h0, rows[i].rr[0]});
      dec(rows[i].a, 1'b1, rows[i].id, 8'hff);
    end
    rdchk(`CSD_IDX_SYSTEM_SPEED_CONTROL, 8'h00);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      {e16, e8, mf, xf} <= k[3:0];
      ea = (k[1] | (k[3] & k[2])) ? csd_pkg::CSD_W8 :
           (k[2] & !k[3]) ? csd_pkg::CSD_W32 : csd_pkg::CSD_W16;
      ei = (k[0] | (k[3] & k[2])) ? csd_pkg::CSD_W8 :
           !k[3] ? csd_pkg::CSD_W32 : csd_pkg::CSD_W16;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({30'h0, acc_o}, {30'h0, ea});
      chk({30'h0, idx_o}, {30'h0, ei});
    end
    @(posedge clk);
    {e16, e8, mf, xf} <= 4'h4;
    rdchk(`CSD_IDX_STAT, 8'h0a);
    dec(24'h008000, 1'b0, 4'h8, 8'hff);
    wr(`CSD_IDX_PORT7_CHIP_SELECT_ENABLE, 8'hef);
    dec(24'h008000, 1'b1, 4'h5, 8'hef);
    wr(`CSD_IDX_PORT7_CHIP_SELECT_ENABLE, 8'hf7);
    dec(24'h001000, 1'b1, 4'h5, 8'hf7);
    wr(16'h0003, 8'h77);
    rdchk(16'h0003, 8'h00);
    bus(1'b1, `CSD_IDX_SYSTEM_SPEED_CONTROL, 8'h04, 4'h0, dq);
    rdchk(`CSD_IDX_SYSTEM_SPEED_CONTROL, 8'h00);
    rst(1'b1);
    rdchk(`CSD_IDX_BCR, 8'h00);
    rdchk(`CSD_IDX_PORT7_CHIP_SELECT_ENABLE, 8'h00);
    tally_and_finish();
  end
endmodule
